//--- dtc_fifo.sv
// Purpose: Small flop based FIFO with valid and ready on both sides
// Assumes: Single clock, DEPTH a power of two
// Notes:   in_ready low when full is the back-pressure toward the serial port
`timescale 1ns/10ps
module dtc_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
   localparam logic [PW:0] CNT_ONE = (PW+1)'(1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wp_ff;
   logic [PW-1:0] rp_ff;
   logic [PW:0] cnt_ff;
   logic do_push;
   logic do_pop;

   assign in_ready = (cnt_ff != FULL_CNT);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rp_ff];
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wp_ff <= wp_ff + PTR_ONE;
         end
         if (do_pop) begin
            rp_ff <= rp_ff + PTR_ONE;
         end
         if (do_push && !do_pop) begin
            cnt_ff <= cnt_ff + CNT_ONE;
         end else if (do_pop && !do_push) begin
            cnt_ff <= cnt_ff - CNT_ONE;
         end
      end
   end

   // Storage needs no reset; it is never read while empty
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_ff[wp_ff] <= in_data;
      end
   end
endmodule // dtc_fifo

//--- dtc_i2c_master.sv
// Purpose: Behavioural serial bus master facing the tag block
// Assumes: Data line has a pull-up resolved by the bench
// Notes:   Clock stands high between frames; 600 ns bit slot
`timescale 1ns/10ps
module dtc_i2c_master (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // ------------------------------------------------------------
   // Bit level
   // ------------------------------------------------------------
   // Data changes only while the clock is low, sampled mid-high
   task automatic slot(input logic v, output logic s);
      #100 sda_pull = !v;
      #200 scl = 1'b1;
      #150 s = sda;
      #150 scl = 1'b0;
   endtask
   task automatic start();
      #113 sda_pull = 1'b0;
      #200 scl = 1'b1;
      #150 sda_pull = 1'b1;
      #150 scl = 1'b0;
   endtask
   task automatic stop();
      #100 sda_pull = 1'b1;
      #200 scl = 1'b1;
      #150 sda_pull = 1'b0;
      #150;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) slot(d[i], s);
      slot(1'b1, s);
      ack = !s;
   endtask
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(!more, s);
   endtask
endmodule // dtc_i2c_master

//--- dtc_pkg.sv
// Purpose: Shared constants and types of the dual interface tag control block
// Assumes: 20 MHz system clock, serial clock well below a quarter of it
// Notes:   All state of the main module is one packed struct declared here
package dtc_pkg;
   // ------------------------------------------------------------
   // Memory geometry
   // ------------------------------------------------------------
   localparam int I2C_BYTES = 8192;
   localparam int RF_WORDS = 2048;
   localparam int RF_WORD_BITS = 32;
   localparam int ADDR_W = $clog2(I2C_BYTES);
   localparam int RF_ADDR_W = $clog2(RF_WORDS);
   localparam int FIFO_DEPTH = 16;

   // ------------------------------------------------------------
   // Device select byte layout
   // ------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [1:0] DEV_FIXED = 2'h3;
   localparam int DEV_TYPE_MSB = 7;
   localparam int DEV_TYPE_LSB = 4;
   localparam int DEV_BANK_BIT = 3;
   localparam int DEV_FIXED_MSB = 2;
   localparam int DEV_FIXED_LSB = 1;
   localparam int DEV_RW_BIT = 0;
   localparam int ADDR_HI_W = ADDR_W - 8;

   // ------------------------------------------------------------
   // Byte and bit counting
   // ------------------------------------------------------------
   localparam logic [3:0] BIT_NONE = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [1:0] BYTE_DEV = 2'h0;
   localparam logic [1:0] BYTE_AHI = 2'h1;
   localparam logic [1:0] BYTE_ALO = 2'h2;
   localparam logic [1:0] BYTE_DATA = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;

   // ------------------------------------------------------------
   // Contactless link rates
   // ------------------------------------------------------------
   localparam int RX_RATE_SLOW_BPS = 1600;
   localparam int RX_RATE_FAST_BPS = 26000;
   localparam int TX_RATE_LOW_BPS = 6600;
   localparam int TX_RATE_HIGH_BPS = 26000;
   localparam int TX_RATE_FAST_BPS = 53000;
   localparam int SUBCARRIER_1_HZ = 423000;
   localparam int SUBCARRIER_2_HZ = 484000;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
   } dtc_i2c_st_type;

   typedef enum logic {RX_ONE_OF_256, RX_ONE_OF_4} dtc_rx_rate_type;
   typedef enum logic [1:0] {TX_LOW, TX_HIGH, TX_FAST} dtc_tx_rate_type;
   typedef enum logic {WRITE_IN_PROGRESS_MODE, COMMAND_ACTIVE_MODE} dtc_act_mode_type;

   typedef struct packed {
      logic bank;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } dtc_wr_type;

   typedef struct packed {
      logic scl_s1, scl_s2, scl_d;
      logic sda_s1, sda_s2, sda_d;
      logic vcc_s1, vcc_s2;
      logic wb_s1, wb_s2;
      logic cb_s1, cb_s2;
      logic fo_s1, fo_s2;
      dtc_i2c_st_type st;
      logic [3:0] bit_cnt;
      logic [1:0] byte_idx;
      logic [7:0] shift;
      logic rw;
      logic bank;
      logic [ADDR_W-1:0] addr;
      logic sda_oe;
      logic rd_next;
      logic push;
      dtc_wr_type push_word;
      logic stop_seen;
      logic standby;
      logic wip;
      logic act_oe;
      logic harv_oe;
      dtc_rx_rate_type rx_rate;
      dtc_tx_rate_type tx_rate;
      logic two_sub;
   } dtc_state_type;
endpackage

//--- dtc_tag_ctrl.sv
// Purpose: Control logic of a dual interface tag: serial slave port,
//          activity output, harvest enable, link rate selection
// Assumes: scl_i, sda_i, vcc_ok, busy flags and field_ok are asynchronous
// Notes:   Rules that the logic below carries out
`timescale 1ns/10ps
module dtc_tag_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic vcc_ok,
   input wire logic rf_write_busy,
   input wire logic rf_cmd_busy,
   input wire dtc_pkg::dtc_act_mode_type rf_out_mode,
   output logic rf_activity_out,
   output logic rf_activity_oe,
   input wire logic harvest_en,
   input wire logic field_ok,
   output logic harvest_oe,
   input wire logic rf_rx_one_of_4,
   input wire logic rf_high_rate,
   input wire logic rf_fast,
   input wire logic rf_two_sub,
   output dtc_pkg::dtc_rx_rate_type rf_rx_rate,
   output dtc_pkg::dtc_tx_rate_type rf_tx_rate,
   output logic rf_tx_two_sub,
   output logic [dtc_pkg::ADDR_W-1:0] mem_addr,
   output logic mem_bank,
   input wire logic [7:0] rd_data,
   output logic rd_next,
   output logic wr_valid,
   input wire logic wr_ready,
   output dtc_pkg::dtc_wr_type wr_data,
   output logic standby,
   output logic wip
);
   import dtc_pkg::*;

   dtc_state_type q;
   dtc_state_type n;
   logic fifo_ready;
   logic fifo_valid;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   function automatic logic dev_match(input logic [7:0] b);
      dev_match = (b[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE) &&
                  (b[DEV_FIXED_MSB:DEV_FIXED_LSB] == DEV_FIXED);
   endfunction

   assign scl_rise = q.scl_s2 && !q.scl_d;
   assign scl_fall = !q.scl_s2 && q.scl_d;
   assign start_cond = q.scl_s2 && q.scl_d && q.sda_d && !q.sda_s2;
   assign stop_cond = q.scl_s2 && q.scl_d && !q.sda_d && q.sda_s2;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n = q;
      n.scl_s1 = scl_i;
      n.scl_s2 = q.scl_s1;
      n.scl_d = q.scl_s2;
      n.sda_s1 = sda_i;
      n.sda_s2 = q.sda_s1;
      n.sda_d = q.sda_s2;
      n.vcc_s1 = vcc_ok;
      n.vcc_s2 = q.vcc_s1;
      n.wb_s1 = rf_write_busy;
      n.wb_s2 = q.wb_s1;
      n.cb_s1 = rf_cmd_busy;
      n.cb_s2 = q.cb_s1;
      n.fo_s1 = field_ok;
      n.fo_s2 = q.fo_s1;
      n.push = 1'b0;
      n.rd_next = 1'b0;

      if (start_cond) begin
         n.st = ST_RX;
         n.bit_cnt = BIT_NONE;
         n.byte_idx = BYTE_DEV;
         n.sda_oe = 1'b0;
         n.stop_seen = 1'b0;
      end else if (stop_cond) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
         n.stop_seen = 1'b1;
      end else begin
         case (q.st)
            ST_IDLE: begin
               n.sda_oe = 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  n.shift = {q.shift[6:0], q.sda_s2};
                  n.bit_cnt = q.bit_cnt + BIT_ONE;
               end else if (scl_fall && q.bit_cnt == BIT_LAST) begin
                  n.bit_cnt = BIT_NONE;
                  n.st = ST_IDLE;
                  case (q.byte_idx)
                     BYTE_DEV: begin
                        // Mismatch leaves the line released until next start
                        if (dev_match(q.shift)) begin
                           n.st = ST_RX_ACK;
                           n.rw = q.shift[DEV_RW_BIT];
                           n.bank = q.shift[DEV_BANK_BIT];
                        end
                     end
                     BYTE_AHI: begin
                        n.addr[ADDR_W-1:8] = q.shift[ADDR_HI_W-1:0];
                        n.st = ST_RX_ACK;
                     end
                     BYTE_ALO: begin
                        n.addr[7:0] = q.shift;
                        n.st = ST_RX_ACK;
                     end
                     default: begin
                        // Full buffer refuses the byte instead of losing it
                        if (fifo_ready) begin
                           n.push = 1'b1;
                           n.push_word = '{bank: q.bank, addr: q.addr, data: q.shift};
                           n.addr = q.addr + ADDR_STEP;
                           n.st = ST_RX_ACK;
                        end
                     end
                  endcase
                  n.sda_oe = (n.st == ST_RX_ACK);
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  if (q.byte_idx == BYTE_DEV && q.rw) begin
                     n.shift = rd_data;
                     n.sda_oe = !rd_data[7];
                     n.bit_cnt = BIT_ONE;
                     n.st = ST_TX;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st = ST_RX;
                     if (q.byte_idx != BYTE_DATA) begin
                        n.byte_idx = q.byte_idx + 2'h1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (q.bit_cnt == BIT_LAST) begin
                     n.sda_oe = 1'b0;
                     n.st = ST_TX_ACK;
                     n.addr = q.addr + ADDR_STEP;
                     n.rd_next = 1'b1;
                  end else begin
                     n.shift = {q.shift[6:0], 1'b0};
                     n.sda_oe = !q.shift[6];
                     n.bit_cnt = q.bit_cnt + BIT_ONE;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise && q.sda_s2) begin
                  n.st = ST_IDLE;
               end else if (scl_fall) begin
                  n.shift = rd_data;
                  n.sda_oe = !rd_data[7];
                  n.bit_cnt = BIT_ONE;
                  n.st = ST_TX;
               end
            end
            default: begin
               n.st = ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end

      // Supply below threshold: port is dead and comes back in standby
      if (!q.vcc_s2) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
         n.push = 1'b0;
         n.rd_next = 1'b0;
         n.stop_seen = 1'b1;
      end

      n.wip = fifo_valid || q.push;
      n.standby = n.stop_seen && !n.wip;

      // ---------------------------------------------------------
      // Contactless side outputs
      // ---------------------------------------------------------
      if (rf_out_mode == COMMAND_ACTIVE_MODE) begin
         n.act_oe = q.vcc_s2 && q.cb_s2;
      end else begin
         n.act_oe = q.vcc_s2 && q.wb_s2;
      end
      n.harv_oe = harvest_en && q.fo_s2;
      n.rx_rate = rf_rx_one_of_4 ? RX_ONE_OF_4 : RX_ONE_OF_256;
      if (!rf_high_rate) begin
         n.tx_rate = TX_LOW;
         n.two_sub = rf_two_sub;
      end else if (rf_fast) begin
         n.tx_rate = TX_FAST;
         n.two_sub = 1'b0;
      end else begin
         n.tx_rate = TX_HIGH;
         n.two_sub = rf_two_sub;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.scl_s1 <= 1'b1;
         q.scl_s2 <= 1'b1;
         q.scl_d <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
         q.sda_d <= 1'b1;
         q.st <= ST_IDLE;
         q.stop_seen <= 1'b1;
         q.standby <= 1'b1;
         q.rx_rate <= RX_ONE_OF_256;
         q.tx_rate <= TX_LOW;
      end else begin
         q <= n;
      end
   end

   // ------------------------------------------------------------
   // Write buffer toward memory
   // ------------------------------------------------------------
   dtc_fifo #(
      .WIDTH($bits(dtc_wr_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(q.push),
      .in_ready(fifo_ready),
      .in_data(q.push_word),
      .out_valid(fifo_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );

   assign wr_valid = fifo_valid;
   assign sda_o = 1'b0;
   assign sda_oe = q.sda_oe;
   assign rf_activity_out = 1'b0;
   assign rf_activity_oe = q.act_oe;
   assign harvest_oe = q.harv_oe;
   assign rf_rx_rate = q.rx_rate;
   assign rf_tx_rate = q.tx_rate;
   assign rf_tx_two_sub = q.two_sub;
   assign mem_addr = q.addr;
   assign mem_bank = q.bank;
   assign rd_next = q.rd_next;
   assign standby = q.standby;
   assign wip = q.wip;
endmodule // dtc_tag_ctrl

//--- dtc_tag_ctrl_bench.sv
// Purpose: Self-checking bench of the tag control block
// Assumes: Memory read data is a fixed pattern of the address
// Notes:   Write sink stalls two cycles in four while draining
`timescale 1ns/10ps
module dtc_tag_ctrl_bench;
   import dtc_pkg::*;
   typedef struct packed {
      dtc_act_mode_type mode;
      logic wb, cb, hen, fok, r4, hi, fast, two, act, harv;
      dtc_rx_rate_type rx;
      dtc_tx_rate_type tx;
      logic twos;
   } dtc_row_type;
   localparam dtc_row_type ROWS [4] = '{
      '{WRITE_IN_PROGRESS_MODE, 1, 0, 1, 1, 0, 0, 0, 1, 1, 1, RX_ONE_OF_256, TX_LOW, 1},
      '{WRITE_IN_PROGRESS_MODE, 0, 1, 0, 1, 1, 1, 0, 0, 0, 0, RX_ONE_OF_4, TX_HIGH, 0},
      '{COMMAND_ACTIVE_MODE, 0, 1, 1, 0, 0, 1, 1, 1, 1, 0, RX_ONE_OF_256, TX_FAST, 0},
      '{COMMAND_ACTIVE_MODE, 1, 0, 1, 1, 1, 1, 0, 1, 0, 1, RX_ONE_OF_4, TX_HIGH, 1}};
   localparam logic [8:0] SELS [6] = '{{8'hA6, 1'b1}, {8'hAE, 1'b1}, {8'hB6, 1'b0},
      {8'h26, 1'b0}, {8'hA2, 1'b0}, {8'hA4, 1'b0}};
   logic clk, rst_n, scl_i, sda_o, sda_oe, vcc_ok, rf_write_busy, rf_cmd_busy;
   logic rf_activity_out, rf_activity_oe, harvest_en, field_ok, harvest_oe;
   logic rf_rx_one_of_4, rf_high_rate, rf_fast, rf_two_sub, rf_tx_two_sub;
   logic mem_bank, rd_next, wr_valid, wr_ready, standby, wip, m_pull, ack, sda_i;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] rd_data, b;
   dtc_act_mode_type rf_out_mode;
   dtc_rx_rate_type rf_rx_rate;
   dtc_tx_rate_type rf_tx_rate;
   dtc_wr_type wr_data;
   int n_mismatch = 0, n_checks = 0, got, n_rd = 0;
   assign sda_i = !((sda_oe && !sda_o) || m_pull);
   assign rd_data = mem_addr[7:0] ^ 8'h5A;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   dtc_tag_ctrl u_dtc_tag_ctrl (.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oe(sda_oe), .vcc_ok(vcc_ok), .rf_write_busy(rf_write_busy),
      .rf_cmd_busy(rf_cmd_busy), .rf_out_mode(rf_out_mode), .rf_activity_out(rf_activity_out),
      .rf_activity_oe(rf_activity_oe), .harvest_en(harvest_en), .field_ok(field_ok),
      .harvest_oe(harvest_oe), .rf_rx_one_of_4(rf_rx_one_of_4), .rf_high_rate(rf_high_rate),
      .rf_fast(rf_fast), .rf_two_sub(rf_two_sub), .rf_rx_rate(rf_rx_rate),
      .rf_tx_rate(rf_tx_rate), .rf_tx_two_sub(rf_tx_two_sub), .mem_addr(mem_addr),
      .mem_bank(mem_bank), .rd_data(rd_data), .rd_next(rd_next), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .standby(standby), .wip(wip));
   dtc_i2c_master u_dtc_i2c_master (.scl(scl_i), .sda_pull(m_pull), .sda(sda_i));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Read byte strobes, counted where they are settled
   always @(negedge clk) begin
      if (rd_next) n_rd++;
   end
   // Select byte alone, framed by start and stop
   task automatic probe(input logic [7:0] sel, input logic exp);
      u_dtc_i2c_master.start();
      u_dtc_i2c_master.wr_byte(sel, ack);
      u_dtc_i2c_master.stop();
      chk(ack, exp);
      tick(4);
   endtask
   initial begin
      tick(40000);
      n_mismatch++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, vcc_ok, rf_write_busy, rf_cmd_busy, harvest_en, field_ok} = '0;
      {rf_rx_one_of_4, rf_high_rate, rf_fast, rf_two_sub, wr_ready} = '0;
      rf_out_mode = WRITE_IN_PROGRESS_MODE;
      tick(6);
      rst_n = 1'b1;
      tick(1);
      chk(standby, 1);
      chk(sda_oe, 0);
      chk(wip, 0);
      chk(wr_valid, 0);
      chk(mem_addr, 0);
      probe(8'hA6, 1'b0);
      vcc_ok = 1'b1;
      tick(10);
      $display("test power_up done");
      foreach (SELS[i]) probe(SELS[i][8:1], SELS[i][0]);
      $display("test select done");
      foreach (ROWS[i]) begin
         rf_out_mode = ROWS[i].mode;
         {rf_write_busy, rf_cmd_busy} = {ROWS[i].wb, ROWS[i].cb};
         {harvest_en, field_ok} = {ROWS[i].hen, ROWS[i].fok};
         {rf_rx_one_of_4, rf_high_rate} = {ROWS[i].r4, ROWS[i].hi};
         {rf_fast, rf_two_sub} = {ROWS[i].fast, ROWS[i].two};
         tick(5);
         chk(rf_activity_oe, ROWS[i].act);
         chk(harvest_oe, ROWS[i].harv);
         chk(rf_rx_rate, ROWS[i].rx);
         chk(rf_tx_rate, ROWS[i].tx);
         chk(rf_tx_two_sub, ROWS[i].twos);
      end
      $display("test rows done");
      // Reader drops its field: harvest lets go, then comes back
      field_ok = 1'b0;
      tick(5);
      chk(harvest_oe, 0);
      field_ok = 1'b1;
      tick(5);
      chk(harvest_oe, 1);
      $display("test field_off done");
      // Fill the write queue past its depth at the top of the address space
      {rf_write_busy, rf_cmd_busy} = 2'b00;
      u_dtc_i2c_master.start();
      u_dtc_i2c_master.wr_byte(8'hAE, ack);
      u_dtc_i2c_master.wr_byte(8'hFF, ack);
      u_dtc_i2c_master.wr_byte(8'hFE, ack);
      chk(ack, 1);
      for (int i = 0; i < 17; i++) begin
         u_dtc_i2c_master.wr_byte(8'h30 + 8'(i), ack);
         chk(ack, i < 16);
      end
      u_dtc_i2c_master.stop();
      tick(4);
      chk(wip, 1);
      chk(standby, 0);
      chk(mem_bank, 1);
      got = 0;
      for (int c = 0; c < 200 && got < 16; c++) begin
         // Ready set here is what the coming rising edge pops with
         wr_ready = c[1];
         if (wr_valid && wr_ready) begin
            chk(wr_data, {1'b1, 13'h1FFE + 13'(got), 8'h30 + 8'(got)});
            got++;
         end
         tick(1);
      end
      chk(got, 16);
      if (got != 16) report_and_stop();
      tick(4);
      chk(wip, 0);
      chk(standby, 1);
      $display("test fill done");
      // Random read: address, repeated start, two bytes
      u_dtc_i2c_master.start();
      u_dtc_i2c_master.wr_byte(8'hA6, ack);
      u_dtc_i2c_master.wr_byte(8'h00, ack);
      u_dtc_i2c_master.wr_byte(8'h10, ack);
      u_dtc_i2c_master.start();
      u_dtc_i2c_master.wr_byte(8'hA7, ack);
      chk(ack, 1);
      u_dtc_i2c_master.rd_byte(1'b1, b);
      chk(b, 8'h10 ^ 8'h5A);
      u_dtc_i2c_master.rd_byte(1'b0, b);
      chk(b, 8'h11 ^ 8'h5A);
      u_dtc_i2c_master.stop();
      tick(4);
      chk(mem_bank, 0);
      chk(standby, 1);
      chk(mem_addr, 13'h0012);
      chk(n_rd, 2);
      $display("test read done");
      rf_out_mode = WRITE_IN_PROGRESS_MODE;
      rf_write_busy = 1'b1;
      tick(5);
      chk(rf_activity_oe, 1);
      vcc_ok = 1'b0;
      tick(5);
      chk(rf_activity_oe, 0);
      chk(standby, 1);
      probe(8'hA6, 1'b0);
      $display("test supply_loss done");
      report_and_stop();
   end
endmodule // dtc_tag_ctrl_bench

//--- dtc_tag_ctrl_sva.sv
// Purpose: Port checks of the tag control block
// Assumes: One clock domain, async active-low reset
// Notes:   Latencies follow the synchroniser depth of the block
`timescale 1ns/10ps
module dtc_tag_ctrl_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic vcc_ok,
   input wire logic rf_write_busy,
   input wire logic rf_cmd_busy,
   input wire dtc_pkg::dtc_act_mode_type rf_out_mode,
   input wire logic rf_activity_out,
   input wire logic rf_activity_oe,
   input wire logic harvest_en,
   input wire logic field_ok,
   input wire logic harvest_oe,
   input wire logic rf_rx_one_of_4,
   input wire dtc_pkg::dtc_rx_rate_type rf_rx_rate,
   input wire dtc_pkg::dtc_tx_rate_type rf_tx_rate,
   input wire logic rf_tx_two_sub,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire dtc_pkg::dtc_wr_type wr_data
);
   import dtc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Pins, activity, harvest, link rates and write head
   // ------------------------------------------------------------
   sda_pull_only_a: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   act_pull_only_a: assert property (rf_activity_out == 1'b0)
      else $error("activity pin driven high");
   act_write_mode_a: assert property (
      (vcc_ok && rf_write_busy && rf_out_mode == WRITE_IN_PROGRESS_MODE)[*4] |=> rf_activity_oe)
      else $error("activity pin idle during write");
   act_cmd_mode_a: assert property (
      (vcc_ok && rf_cmd_busy && rf_out_mode == COMMAND_ACTIVE_MODE)[*4] |=> rf_activity_oe)
      else $error("activity pin idle during command");
   act_release_a: assert property (
      (rf_out_mode == WRITE_IN_PROGRESS_MODE ? !rf_write_busy : !rf_cmd_busy)[*4]
      |=> !rf_activity_oe) else $error("activity pin held without cause");
   act_no_supply_a: assert property ((!vcc_ok)[*4] |=> !rf_activity_oe)
      else $error("activity pin active without supply");
   sda_no_supply_a: assert property ((!vcc_ok)[*4] |=> !sda_oe)
      else $error("data pin pulled without supply");
   harv_disabled_a: assert property (!harvest_en |=> !harvest_oe)
      else $error("harvest on while disabled");
   harv_weak_a: assert property ((!field_ok)[*4] |=> !harvest_oe)
      else $error("harvest on with weak field");
   harv_on_a: assert property ((harvest_en && field_ok)[*4] |=> harvest_oe)
      else $error("harvest off while enabled");
   fast_one_sub_a: assert property (rf_tx_rate == TX_FAST |-> !rf_tx_two_sub)
      else $error("fast rate with two subcarriers");
   rx_coding_a: assert property (rf_rx_one_of_4 |=> rf_rx_rate == RX_ONE_OF_4)
      else $error("incoming coding not followed");
   wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
      else $error("write head changed while stalled");
   cover property (rf_activity_oe);
   cover property (wr_valid && !wr_ready);
   cover property (rf_tx_rate == TX_FAST);
endmodule // dtc_tag_ctrl_sva
bind dtc_tag_ctrl dtc_tag_ctrl_sva u_dtc_tag_ctrl_sva (.clk(clk), .rst_n(rst_n), .sda_o(sda_o),
   .sda_oe(sda_oe), .vcc_ok(vcc_ok), .rf_write_busy(rf_write_busy), .rf_cmd_busy(rf_cmd_busy),
   .rf_out_mode(rf_out_mode), .rf_activity_out(rf_activity_out),
   .rf_activity_oe(rf_activity_oe), .harvest_en(harvest_en), .field_ok(field_ok),
   .harvest_oe(harvest_oe), .rf_rx_one_of_4(rf_rx_one_of_4), .rf_rx_rate(rf_rx_rate),
   .rf_tx_rate(rf_tx_rate), .rf_tx_two_sub(rf_tx_two_sub), .wr_valid(wr_valid),
   .wr_ready(wr_ready), .wr_data(wr_data));
